// File: pdcs_regs.svh
// Register indices, field positions, reset values and timing counts of the device control block
`ifndef PDCS_REGS_SVH
`define PDCS_REGS_SVH

// ****************************************************************
// Register indices (word index; byte address is four times this)
// ****************************************************************
`define PDCS_CTL_IDX          10'h048
`define PDCS_STS_IDX          10'h04A
`define PDCS_DBG_IDX          10'h0F0

// ****************************************************************
// Control register fields
// ****************************************************************
`define PDCS_CTL_CORR_BIT     0
`define PDCS_CTL_NFAT_BIT     1
`define PDCS_CTL_FAT_BIT      2
`define PDCS_CTL_UNSUP_BIT    3
`define PDCS_CTL_RO_BIT       4
`define PDCS_CTL_MPS_LSB      5
`define PDCS_CTL_MPS_MSB      7
`define PDCS_CTL_WTAG_BIT     8
`define PDCS_CTL_PHANT_BIT    9
`define PDCS_CTL_AUXPM_BIT    10
`define PDCS_CTL_NSNP_BIT     11
`define PDCS_CTL_MAX_READ_REQ_SIZE_LSB     12
`define PDCS_CTL_MAX_READ_REQ_SIZE_MSB     14
`define PDCS_CTL_WR_MASK      16'h01EF
`define PDCS_CTL_RESET        16'h0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define PDCS_STS_FLAG_LSB     0
`define PDCS_STS_FLAG_MSB     3
`define PDCS_STS_AUX_POWER_SEEN_BIT    4
`define PDCS_STS_TPEND_BIT    5
`define PDCS_STS_RESET        16'h0000

// ****************************************************************
// Debug tag control register and payload figures
// ****************************************************************
`define PDCS_DBG_SEQ_BIT      0
`define PDCS_MPS_MAX_CODE     3'h4
`define PDCS_MIN_BYTES        12'h080
`define PDCS_NARROW_TAG_MAX   8'h1F
`define PDCS_ANSWER_CYCLES    1

`endif

// File: pdcs_pkg.sv
// Types shared by the device control and status register block
package pdcs_pkg;

   // Register word as seen by software
   typedef logic [15:0] pdcs_reg_t;

   // Bus answer sequencer
   typedef enum logic [0:0] {
      PDCS_BUS_IDLE   = 1'b0,
      PDCS_BUS_ANSWER = 1'b1
   } pdcs_bus_e;

endpackage : pdcs_pkg

// File: pdcs_err_flags.sv
// Sticky write-one-to-clear error flags
`timescale 1ns/1ns
`default_nettype none

module pdcs_err_flags (
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [3:0] event_in,
   input  wire logic [3:0] clear_in,
   output logic      [3:0] flags_out
);

   logic [3:0] next_flags;

   // Set beats clear so an event in the clearing cycle survives
   assign next_flags = (flags_out & ~clear_in) | event_in;

   // Flag storage
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         flags_out <= 4'h0;
      end else begin
         flags_out <= next_flags;
      end
   end

endmodule : pdcs_err_flags
`default_nettype wire

// File: pdcs_tag_gen.sv
// Debug sequential tag generator
`timescale 1ns/1ns
`default_nettype none

`include "pdcs_regs.svh"

module pdcs_tag_gen (
   input  wire logic       sys_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       seq_en_in,
   input  wire logic       wide_in,
   input  wire logic       take_in,
   output logic      [7:0] tag_out
);

   logic [7:0] next_tag;
   logic [7:0] tag_inc;
   logic       narrow_wrap;

   // Narrow range wraps past 31; a stale wide tag also folds back to 0
   assign tag_inc     = tag_out + 8'h01;
   assign narrow_wrap = !wide_in && (tag_out >= `PDCS_NARROW_TAG_MAX);
   assign next_tag    = !seq_en_in  ? 8'h00 :
                        !take_in    ? tag_out :
                        narrow_wrap ? 8'h00 : tag_inc;

   // Tag register; parked at zero outside debug so entry starts clean
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         tag_out <= 8'h00;
      end else begin
         tag_out <= next_tag;
      end
   end

endmodule : pdcs_tag_gen
`default_nettype wire

// File: pdcs_dev_ctl_sts.sv
// Device control and status register pair with error logging and reporting gates
//
// What this block does
// R1: Control bit 0 enables correctable error reports; read-write, resets zero.
// R2: Control bit 1 enables non-fatal error reports; read-write, resets zero.
// R3: Control bit 2 enables fatal error reports; read-write, resets zero.
// R4: Control bit 3 enables unsupported request reports; read-write, resets zero.
// R5: Relaxed ordering enable bit 4 reads zero; originated requests never use it.
// R6: Bits 7:5 choose max payload 128 to 2048 bytes; reset code zero.
// R7: Payload codes 5 to 7 behave like 128 bytes.
// R8: Bit 8 only matters in tag debug: tags 0-31 clear, 0-255 set.
// R9: Phantom function enable bit 9 is hardwired zero.
// R10: Aux power management enable bit 10 reads zero.
// R11: No-snoop bit 11 reads zero; never originated; forwarded traffic unchanged.
// R12: Read request size 14:12 reads zero; originate at most 128 bytes; forward unchanged.
// R13: Status bit 0 logs correctable errors; write one clears; resets zero.
// R14: Status bit 1 logs non-fatal errors; write one clears.
// R15: Status bit 2 logs fatal errors; write one clears.
// R16: Status bit 3 logs unsupported requests; write one clears.
// R17: Errors are logged regardless of enables; enables gate reports only.
// R18: Aux power detected status bit 4 is hardwired zero.
// R19: Transactions pending status bit 5 is hardwired zero.
// R20: Read-only and reserved bits ignore writes; reserved bits read zero.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

`include "pdcs_regs.svh"

module pdcs_dev_ctl_sts
   import pdcs_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Error events from the port logic, one-cycle pulses
   input  wire logic        corr_err_in,
   input  wire logic        nonfatal_err_in,
   input  wire logic        fatal_err_in,
   input  wire logic        unsup_req_in,
   // Gated report requests to the message generator
   output logic             corr_err_report_out,
   output logic             nonfatal_err_report_out,
   output logic             fatal_err_report_out,
   output logic             unsup_req_report_out,
   // Payload and request sizing
   output logic      [11:0] max_payload_bytes_out,
   output logic      [11:0] max_read_req_bytes_out,
   // Attributes on originated requests
   output logic             orig_relaxed_order_out,
   output logic             orig_no_snoop_out,
   // Pass-through attributes of forwarded traffic
   input  wire logic        fwd_no_snoop_in,
   input  wire logic [2:0]  fwd_read_size_in,
   output logic             fwd_no_snoop_out,
   output logic      [2:0]  fwd_read_size_out,
   // Debug tag generation
   input  wire logic        tag_take_in,
   output logic      [7:0]  debug_tag_out
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Payload code to byte count; reserved codes fall back to the minimum
   function automatic logic [11:0] pdcs_payload_bytes(input logic [2:0] code);
      logic [11:0] bytes;
      bytes = `PDCS_MIN_BYTES;
      if (code <= `PDCS_MPS_MAX_CODE) begin
         bytes = `PDCS_MIN_BYTES << code;
      end
      return bytes;
   endfunction : pdcs_payload_bytes

   // Expand two byte enables into a 16-bit lane mask for a register write
   function automatic pdcs_reg_t pdcs_lane_mask(input logic [1:0] be);
      pdcs_reg_t mask;
      mask = {{8{be[1]}}, {8{be[0]}}};
      return mask;
   endfunction : pdcs_lane_mask

   // ****************************************************************
   // Declarations
   // ****************************************************************

   pdcs_reg_t   ctl;
   pdcs_reg_t   next_ctl;
   logic        seq_tag_dbg;
   logic        next_seq_tag_dbg;
   pdcs_bus_e   bus_state;
   pdcs_bus_e   next_bus_state;
   logic [31:0] next_readdata;

   wire         bus_req;
   wire         bus_commit;
   wire         hit_ctl;
   wire         hit_sts;
   wire         hit_dbg;
   wire         wr_ctl;
   wire         wr_sts;
   wire         wr_dbg;
   pdcs_reg_t   lane_mask;
   pdcs_reg_t   wr_bits;
   pdcs_reg_t   ctl_view;
   pdcs_reg_t   sts_view;
   logic [3:0]  err_events;
   logic [3:0]  err_clear;
   logic [3:0]  err_flags;
   logic [3:0]  report_enables;
   logic [3:0]  next_reports;
   logic [2:0]  mps_code;
   logic        wide_tag_en;

   // ****************************************************************
   // Bus handshake
   // ****************************************************************

   // Every access waits exactly one cycle: the first cycle loads read data,
   // the second drops waitrequest and commits. Fixed latency keeps the
   // read path registered without a combinational mux to the bus.
   assign bus_req    = avs_read_in || avs_write_in;
   assign bus_commit = bus_req && (bus_state == PDCS_BUS_ANSWER);
   assign avs_waitrequest_out = bus_req && (bus_state == PDCS_BUS_IDLE);

   // Sequencer next state
   always_comb begin
      next_bus_state = PDCS_BUS_IDLE;
      case (bus_state)
         PDCS_BUS_IDLE: begin
            if (bus_req) begin
               next_bus_state = PDCS_BUS_ANSWER;
            end
         end
         PDCS_BUS_ANSWER: begin
            next_bus_state = PDCS_BUS_IDLE;
         end
         default: begin
            next_bus_state = PDCS_BUS_IDLE;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         bus_state <= PDCS_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************

   // Unmapped addresses read zero and drop writes, yet still complete
   assign hit_ctl = (avs_address_in == `PDCS_CTL_IDX);
   assign hit_sts = (avs_address_in == `PDCS_STS_IDX);
   assign hit_dbg = (avs_address_in == `PDCS_DBG_IDX);

   assign wr_ctl = bus_commit && avs_write_in && hit_ctl;
   assign wr_sts = bus_commit && avs_write_in && hit_sts;
   assign wr_dbg = bus_commit && avs_write_in && hit_dbg;

   // Only the low two byte lanes carry register bits
   assign lane_mask = pdcs_lane_mask(avs_byteenable_in[1:0]);
   assign wr_bits   = avs_writedata_in[15:0] & lane_mask;

   // ****************************************************************
   // Device control register
   // ****************************************************************

   // Only enables, payload code and wide tag bit store; the rest are dropped
   assign next_ctl = wr_ctl
                   ? ((ctl & ~(lane_mask & `PDCS_CTL_WR_MASK))   // R20
                      | (wr_bits & `PDCS_CTL_WR_MASK))          // R1 R2 R3 R4 R6 R8
                   : ctl;

   // Control storage
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ctl <= `PDCS_CTL_RESET;
      end else begin
         ctl <= next_ctl;
      end
   end

   // Software view: fixed-zero fields never come from storage
   always_comb begin
      ctl_view = 16'h0000;
      ctl_view[`PDCS_CTL_CORR_BIT]  = ctl[`PDCS_CTL_CORR_BIT];   // R1
      ctl_view[`PDCS_CTL_NFAT_BIT]  = ctl[`PDCS_CTL_NFAT_BIT];   // R2
      ctl_view[`PDCS_CTL_FAT_BIT]   = ctl[`PDCS_CTL_FAT_BIT];    // R3
      ctl_view[`PDCS_CTL_UNSUP_BIT] = ctl[`PDCS_CTL_UNSUP_BIT];  // R4
      ctl_view[`PDCS_CTL_RO_BIT]    = 1'b0;                      // R5
      ctl_view[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB] =
         ctl[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB];               // R6
      ctl_view[`PDCS_CTL_WTAG_BIT]  = ctl[`PDCS_CTL_WTAG_BIT];   // R8
      ctl_view[`PDCS_CTL_PHANT_BIT] = 1'b0;                      // R9
      ctl_view[`PDCS_CTL_AUXPM_BIT] = 1'b0;                      // R10
      ctl_view[`PDCS_CTL_NSNP_BIT]  = 1'b0;                      // R11
      ctl_view[`PDCS_CTL_MAX_READ_REQ_SIZE_MSB:`PDCS_CTL_MAX_READ_REQ_SIZE_LSB] = 3'h0;   // R12
   end

   // Named fields used by the datapath
   assign report_enables = ctl[`PDCS_CTL_UNSUP_BIT:`PDCS_CTL_CORR_BIT];
   assign mps_code       = ctl[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB];
   assign wide_tag_en    = ctl[`PDCS_CTL_WTAG_BIT];

   // ****************************************************************
   // Device status register
   // ****************************************************************

   // Bit order: correctable, non-fatal, fatal, unsupported request
   assign err_events = {unsup_req_in, fatal_err_in, nonfatal_err_in, corr_err_in};

   // Write one clears, lane by lane; zero bits leave flags alone
   assign err_clear = wr_sts ? wr_bits[`PDCS_STS_FLAG_MSB:`PDCS_STS_FLAG_LSB] : 4'h0;

   // Logging ignores the enables so software still sees masked errors
   pdcs_err_flags u_err_flags (                              // R13 R14 R15 R16 R17
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .event_in   (err_events),
      .clear_in   (err_clear),
      .flags_out  (err_flags)
   );

   // Software view of status
   always_comb begin
      sts_view = `PDCS_STS_RESET;
      sts_view[`PDCS_STS_FLAG_MSB:`PDCS_STS_FLAG_LSB] = err_flags;  // R13 R14 R15 R16
      sts_view[`PDCS_STS_AUX_POWER_SEEN_BIT] = 1'b0;                       // R18
      sts_view[`PDCS_STS_TPEND_BIT] = 1'b0;                       // R19
   end

   // ****************************************************************
   // Debug tag control register
   // ****************************************************************

   // Sequential tag debug switch; only its low bit stores
   assign next_seq_tag_dbg = (wr_dbg && lane_mask[0]) ?
                             avs_writedata_in[`PDCS_DBG_SEQ_BIT] : seq_tag_dbg;

   // Debug switch storage
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         seq_tag_dbg <= 1'b0;
      end else begin
         seq_tag_dbg <= next_seq_tag_dbg;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************

   // Loaded in the wait cycle, so data is stable when waitrequest drops;
   // reserved bits and upper lanes read zero
   assign next_readdata = (!bus_req || !avs_read_in) ? avs_readdata_out :
                          hit_ctl ? {16'h0000, ctl_view} :                // R20
                          hit_sts ? {16'h0000, sts_view} :                // R20
                          hit_dbg ? {31'h0000_0000, seq_tag_dbg} :
                          32'h0000_0000;

   // Read data register
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         avs_readdata_out <= next_readdata;
      end
   end

   // ****************************************************************
   // Error reporting
   // ****************************************************************

   // Each event asks for a message only if its enable is set
   assign next_reports = err_events & report_enables;   // R1 R2 R3 R4 R17

   // Report pulses, one cycle late to stay registered
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         corr_err_report_out     <= 1'b0;
         nonfatal_err_report_out <= 1'b0;
         fatal_err_report_out    <= 1'b0;
         unsup_req_report_out    <= 1'b0;
      end else begin
         corr_err_report_out     <= next_reports[0];
         nonfatal_err_report_out <= next_reports[1];
         fatal_err_report_out    <= next_reports[2];
         unsup_req_report_out    <= next_reports[3];
      end
   end

   // ****************************************************************
   // Sizing and attributes
   // ****************************************************************

   // Payload limit follows the code; originated reads stay at the minimum.
   // Forwarded attributes are carried through untouched, one cycle late.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         max_payload_bytes_out  <= `PDCS_MIN_BYTES;
         max_read_req_bytes_out <= `PDCS_MIN_BYTES;
         orig_relaxed_order_out <= 1'b0;
         orig_no_snoop_out      <= 1'b0;
         fwd_no_snoop_out       <= 1'b0;
         fwd_read_size_out      <= 3'h0;
      end else begin
         max_payload_bytes_out  <= pdcs_payload_bytes(mps_code);  // R6 R7
         max_read_req_bytes_out <= `PDCS_MIN_BYTES;              // R12
         orig_relaxed_order_out <= 1'b0;                         // R5
         orig_no_snoop_out      <= 1'b0;                         // R11
         fwd_no_snoop_out       <= fwd_no_snoop_in;              // R11
         fwd_read_size_out      <= fwd_read_size_in;             // R12
      end
   end

   // ****************************************************************
   // Debug tag generation
   // ****************************************************************

   // Wide tag bit only steers the counter while debug is on
   pdcs_tag_gen u_tag_gen (                                  // R8
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .seq_en_in  (seq_tag_dbg),
      .wide_in    (wide_tag_en),
      .take_in    (tag_take_in),
      .tag_out    (debug_tag_out)
   );

endmodule : pdcs_dev_ctl_sts
`default_nettype wire

// File: pdcs_dev_ctl_sts_props.sv
// Concurrent checks on the port behaviour of the device control and status block
`timescale 1ns/1ns
`default_nettype none

module pdcs_dev_ctl_sts_props (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        corr_err_in,
   input  wire logic        nonfatal_err_in,
   input  wire logic        fatal_err_in,
   input  wire logic        unsup_req_in,
   input  wire logic        corr_err_report_out,
   input  wire logic        nonfatal_err_report_out,
   input  wire logic        fatal_err_report_out,
   input  wire logic        unsup_req_report_out,
   input  wire logic [11:0] max_payload_bytes_out,
   input  wire logic [11:0] max_read_req_bytes_out,
   input  wire logic        orig_relaxed_order_out,
   input  wire logic        orig_no_snoop_out,
   input  wire logic        fwd_no_snoop_in,
   input  wire logic [2:0]  fwd_read_size_in,
   input  wire logic        fwd_no_snoop_out,
   input  wire logic [2:0]  fwd_read_size_out
);
   // ****************
   // Single clock domain, reset masks every check
   // ****************
   default clocking dflt @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   // A report pulse must trace back to its event one cycle earlier
   corr_rpt_gate_a: assert property (corr_err_report_out |-> $past(corr_err_in))
      else $error("correctable report without event");
   nfat_rpt_gate_a: assert property (nonfatal_err_report_out |-> $past(nonfatal_err_in))
      else $error("non-fatal report without event");
   fat_rpt_gate_a: assert property (fatal_err_report_out |-> $past(fatal_err_in))
      else $error("fatal report without event");
   unsup_rpt_gate_a: assert property (unsup_req_report_out |-> $past(unsup_req_in))
      else $error("unsupported request report without event");

   // Attributes on originated traffic never set
   relaxed_never_a: assert property (!orig_relaxed_order_out)
      else $error("relaxed ordering set on originated request");
   snoop_never_a: assert property (!orig_no_snoop_out)
      else $error("no-snoop set on originated request");

   // Sizes: payload only legal figures, read request fixed small
   payload_legal_a: assert property (max_payload_bytes_out inside
      {12'h080, 12'h100, 12'h200, 12'h400, 12'h800}) else $error("illegal payload size");
   rdreq_fixed_a: assert property (max_read_req_bytes_out == 12'h080)
      else $error("read request size not 128");

   // Forwarded attributes pass unchanged one cycle late; skip the cycle after reset
   fwd_snoop_pass_a: assert property (!$past(sys_rst_in) |->
      fwd_no_snoop_out == $past(fwd_no_snoop_in)) else $error("forwarded no-snoop altered");
   fwd_size_pass_a: assert property (!$past(sys_rst_in) |->
      fwd_read_size_out == $past(fwd_read_size_in)) else $error("forwarded size altered");
endmodule : pdcs_dev_ctl_sts_props

bind pdcs_dev_ctl_sts pdcs_dev_ctl_sts_props pdcs_dev_ctl_sts_props_inst (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .corr_err_in(corr_err_in),
   .nonfatal_err_in(nonfatal_err_in), .fatal_err_in(fatal_err_in), .unsup_req_in(unsup_req_in),
   .corr_err_report_out(corr_err_report_out), .nonfatal_err_report_out(nonfatal_err_report_out),
   .fatal_err_report_out(fatal_err_report_out), .unsup_req_report_out(unsup_req_report_out),
   .max_payload_bytes_out(max_payload_bytes_out), .orig_no_snoop_out(orig_no_snoop_out),
   .max_read_req_bytes_out(max_read_req_bytes_out), .fwd_no_snoop_in(fwd_no_snoop_in),
   .orig_relaxed_order_out(orig_relaxed_order_out), .fwd_read_size_in(fwd_read_size_in),
   .fwd_no_snoop_out(fwd_no_snoop_out), .fwd_read_size_out(fwd_read_size_out)
);

`default_nettype wire

// File: pdcs_dev_ctl_sts_bench.sv
// Self-checking bench for the device control and status register pair
`timescale 1ns/1ns
`default_nettype none

`include "pdcs_regs.svh"

module pdcs_dev_ctl_sts_bench;
   // ****************
   // Stimulus and observed signals
   // ****************
   logic              sys_clk_in = 1'b0;
   logic              sys_rst_in = 1'b1;
   logic [9:0]        adr        = 10'h000;
   logic              rd_en      = 1'b0;
   logic              wr_en      = 1'b0;
   logic [31:0]       wdata      = 32'h0000_0000;
   logic [3:0]        be         = 4'h0;
   logic [3:0]        ev         = 4'h0;
   logic              fwd_ns     = 1'b0;
   logic [2:0]        fwd_sz     = 3'h0;
   logic              take       = 1'b0;
   wire  logic [31:0] rdata;
   wire  logic        waitreq;
   wire  logic [3:0]  rpt;
   wire  logic [11:0] mps_b;
   wire  logic [11:0] mrr_b;
   wire  logic        ro_o;
   wire  logic        ns_o;
   wire  logic        fwd_ns_o;
   wire  logic [2:0]  fwd_sz_o;
   wire  logic [7:0]  tag;
   int                n_mismatch = 0;
   int                checks     = 0;
   int                cyc        = 0;

   pdcs_dev_ctl_sts pdcs_dev_ctl_sts_inst (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
      .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .corr_err_in(ev[0]), .nonfatal_err_in(ev[1]), .fatal_err_in(ev[2]), .unsup_req_in(ev[3]),
      .corr_err_report_out(rpt[0]), .nonfatal_err_report_out(rpt[1]),
      .fatal_err_report_out(rpt[2]), .unsup_req_report_out(rpt[3]),
      .max_payload_bytes_out(mps_b), .max_read_req_bytes_out(mrr_b),
      .orig_relaxed_order_out(ro_o), .orig_no_snoop_out(ns_o), .fwd_no_snoop_in(fwd_ns),
      .fwd_read_size_in(fwd_sz), .fwd_no_snoop_out(fwd_ns_o), .fwd_read_size_out(fwd_sz_o),
      .tag_take_in(take), .debug_tag_out(tag)
   );

   // Clock, hang guard and free-running forwarded traffic
   always #20 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      fwd_sz <= fwd_sz + 3'h1;
      fwd_ns <= fwd_sz[1];
      if (cyc == 4000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Bus cycle: hold until waitrequest is seen low at a rising edge, take data and
   // release right at that edge; only the bench timeout ends a stuck wait
   task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d,
                      input logic [3:0] b, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      adr <= a;
      rd_en <= !wr;
      wr_en <= wr;
      wdata <= {16'hFFFF, d};
      be <= b;
      @(posedge sys_clk_in);
      while (waitreq !== 1'b0) begin
         n++;
         @(posedge sys_clk_in);
      end
      q = rdata[15:0];
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      chk("wait cycles", 16'(n), 16'(`PDCS_ANSWER_CYCLES));
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] b);
      logic [15:0] q;
      bus(1'b1, a, d, b, q);
   endtask : wr

   task automatic rdc(input string nm, input logic [9:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, 4'h3, q);
      chk(nm, q, e);
   endtask : rdc

   // One-cycle event, report expected in the following cycle
   task automatic fire(input logic [3:0] m, input logic [3:0] en);
      @(posedge sys_clk_in);
      ev <= m;
      @(posedge sys_clk_in);
      ev <= 4'h0;
      @(negedge sys_clk_in);
      chk("reports", {12'h000, rpt}, {12'h000, m & en});
   endtask : fire

   task automatic take_n(input int n);
      @(posedge sys_clk_in);
      take <= 1'b1;
      repeat (n - 1) @(posedge sys_clk_in);
      @(posedge sys_clk_in);
      take <= 1'b0;
      @(negedge sys_clk_in);
   endtask : take_n

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset(input int n);
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      repeat (n) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      @(negedge sys_clk_in);
      chk("payload after reset", {4'h0, mps_b}, 16'h0080);
      rdc("control reset", `PDCS_CTL_IDX, 16'h0000);
      rdc("status reset", `PDCS_STS_IDX, 16'h0000);
   endtask : t_reset

   // Read-only bits stay zero; byte lanes write alone; unmapped write lands nowhere
   task automatic t_ctl();
      wr(`PDCS_CTL_IDX, 16'hFFFF, 4'h3);
      rdc("control ones", `PDCS_CTL_IDX, 16'h01EF);
      wr(`PDCS_CTL_IDX, 16'h0000, 4'h3);
      wr(`PDCS_CTL_IDX, 16'hFFFF, 4'h1);
      rdc("control lane0", `PDCS_CTL_IDX, 16'h00EF);
      wr(`PDCS_CTL_IDX, 16'h0000, 4'h3);
      wr(`PDCS_CTL_IDX, 16'hFFFF, 4'h2);
      rdc("control lane1", `PDCS_CTL_IDX, 16'h0100);
      wr(`PDCS_CTL_IDX, 16'h0000, 4'h3);
      wr(10'h049, 16'hFFFF, 4'h3);
      rdc("control after stray", `PDCS_CTL_IDX, 16'h0000);
      rdc("unmapped", 10'h100, 16'h0000);
   endtask : t_ctl

   // Every payload code, reserved ones fall back to the smallest size
   task automatic t_mps();
      logic [15:0] v;
      for (int c = 0; c < 8; c++) begin
         v = 16'(c) << 5;
         wr(`PDCS_CTL_IDX, v, 4'h3);
         rdc("payload code", `PDCS_CTL_IDX, v);
         chk("payload bytes", {4'h0, mps_b}, (c < 5) ? (16'h0080 << c) : 16'h0080);
      end
   endtask : t_mps

   // Logging ignores enables; clear by writing ones; enables gate reports only
   task automatic t_err();
      wr(`PDCS_CTL_IDX, 16'h0000, 4'h3);
      for (int i = 0; i < 4; i++) begin
         fire(4'(1 << i), 4'h0);
         rdc("status log", `PDCS_STS_IDX, 16'((2 << i) - 1));
      end
      wr(`PDCS_STS_IDX, 16'hFFF0, 4'h3);
      rdc("status ro", `PDCS_STS_IDX, 16'h000F);
      wr(`PDCS_STS_IDX, 16'h0005, 4'h3);
      rdc("status clr a", `PDCS_STS_IDX, 16'h000A);
      wr(`PDCS_STS_IDX, 16'h000A, 4'h3);
      rdc("status clr b", `PDCS_STS_IDX, 16'h0000);
      wr(`PDCS_CTL_IDX, 16'h000F, 4'h3);
      for (int i = 0; i < 4; i++) fire(4'(1 << i), 4'hF);
      wr(`PDCS_CTL_IDX, 16'h0005, 4'h3);
      fire(4'hF, 4'h5);
   endtask : t_err

   // Debug tags wrap past 31 when narrow and count past 31 when wide; off means zero whatever is taken
   task automatic t_tag();
      wr(`PDCS_CTL_IDX, 16'h0000, 4'h3);
      wr(`PDCS_DBG_IDX, 16'h0001, 4'h3);
      take_n(33);
      chk("narrow tag", {8'h00, tag}, 16'h0001);
      wr(`PDCS_CTL_IDX, 16'h0100, 4'h3);
      take_n(40);
      chk("wide tag", {8'h00, tag}, 16'h0029);
      wr(`PDCS_DBG_IDX, 16'h0000, 4'h3);
      take_n(5);
      chk("tag off", {8'h00, tag}, 16'h0000);
   endtask : t_tag

   // ****************
   // Main sequence and verdict
   // ****************
   task automatic stop_test();
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   initial begin
      t_reset(12);
      t_ctl();
      t_mps();
      t_err();
      t_tag();
      t_reset(2);
      stop_test();
   end
endmodule : pdcs_dev_ctl_sts_bench

`default_nettype wire
